// >>> shared/mfc_pkg.sv
// Functional notes
// [R1] management data field is the low sixteen bits, write value or read result
// [R2] pause time in flow control bits 16 to 31 goes into every sent pause frame
// [R3] with flow control enable set, received pause frames suspend the transmitter
// [R4] host requests a pause frame by writing one to busy bit 0
// [R5] busy bit stays one while the requested pause frame is being sent
// [R6] busy bit is cleared once the requested pause frame has been sent; the code keeps it set if one is written to bit 0 in that cycle
// [R7] host checks busy is zero before requesting another pause frame
// [R8] eleven-bit maximum frame size sits in counter control bits 3 to 13
// [R9] every transmitted frame longer than the maximum counts as a long frame
// [R10] software must write one into counter control bit 1
// [R11] software fills reserved word at 10Ch to 10Fh with all ones
// [R12] software fills reserved word at 110h to 113h with all ones
// [R13] pause lasts quanta times 512 bit periods at link speed, then resumes
package mfc_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // byte addresses
  localparam logic [11:0] ADDR_MGMT_DATA = 12'h018;
  localparam logic [11:0] ADDR_FLOW_CTRL = 12'h01C;
  localparam logic [11:0] ADDR_CNT_CTRL = 12'h100;
  localparam logic [11:0] ADDR_RSVD_A = 12'h10C;
  localparam logic [11:0] ADDR_RSVD_B = 12'h110;
  localparam logic [11:0] ADDR_LONG_CNT = 12'h120;
  // field positions
  localparam int unsigned MGMT_LSB = 0;
  localparam int unsigned MGMT_W = 16;
  localparam int unsigned PT_LSB = 16;
  localparam int unsigned PT_W = 16;
  localparam int unsigned FCE_BIT = 1;
  localparam int unsigned FCB_BIT = 0;
  localparam int unsigned MXF_LSB = 3;
  localparam int unsigned MXF_W = 11;
  localparam int unsigned CC_RSVD_BIT = 1;
  localparam int unsigned LEN_W = 16;
  // reset values
  localparam logic [15:0] PT_RESET = 16'h0050;
  localparam logic FCE_RESET = 1'b1;
  localparam logic [10:0] MXF_RESET = 11'h5EE;
  localparam logic CC_RSVD_RESET = 1'b1;
  localparam logic [31:0] RSVD_RESET = 32'h0000_0000;
  localparam logic [15:0] MGMT_RESET = 16'h0000;
  // timing: one pause quantum is a slot of 512 bit periods
  localparam int unsigned SLOT_BITS = 512;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BIT_NS_100M = 10;
  localparam int unsigned BIT_NS_10M = 100;
  localparam int unsigned SLOT_CYC_100M = (SLOT_BITS * BIT_NS_100M) / CLK_PERIOD_NS;
  localparam int unsigned SLOT_CYC_10M = (SLOT_BITS * BIT_NS_10M) / CLK_PERIOD_NS;
  localparam int unsigned SLOT_CNT_W = 12;
  // pause frame request states
  typedef enum logic [1:0] {
    MFC_PTX_IDLE = 2'b01,
    MFC_PTX_BUSY = 2'b10
  } mfc_ptx_state_t;
endpackage

// >>> hw/mfc_pause_timer.sv
`timescale 1ns/1ns
`default_nettype none
module mfc_pause_timer
  import mfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_start,
  input wire logic [PT_W-1:0] i_quanta,
  input wire logic i_speed_100,
  output logic o_paused
);
  // refuse slot lengths that the slot counter cannot hold
  if (SLOT_CYC_10M >= (1 << SLOT_CNT_W) || SLOT_CYC_100M < 1)
  begin : bad_slot_w
    $error("slot cycle count does not fit the slot counter");
  end

  logic paused_reg, paused_next;
  logic [PT_W-1:0] quanta_reg, quanta_next;
  logic [SLOT_CNT_W-1:0] slot_reg, slot_next;
  logic [SLOT_CNT_W-1:0] slot_load;

  // slot length follows the current link speed
  assign slot_load = i_speed_100 ? SLOT_CNT_W'(SLOT_CYC_100M - 1) : SLOT_CNT_W'(SLOT_CYC_10M - 1); // R13

  // countdown of quanta, each one slot long; a new frame restarts it
  always_comb
  begin
    paused_next = paused_reg;
    quanta_next = quanta_reg;
    slot_next = slot_reg;
    if (!i_enable)
    begin
      paused_next = 1'b0; // R3
      quanta_next = '0;
      slot_next = '0;
    end
    else if (i_start)
    begin
      paused_next = (i_quanta != '0); // R3
      quanta_next = i_quanta;
      slot_next = slot_load;
    end
    else if (paused_reg)
    begin
      if (slot_reg != '0)
        slot_next = slot_reg - SLOT_CNT_W'(1);
      else if (quanta_reg <= PT_W'(1))
      begin
        paused_next = 1'b0; // R13
        quanta_next = '0;
      end
      else
      begin
        quanta_next = quanta_reg - PT_W'(1);
        slot_next = slot_load; // R13
      end
    end
  end

  // state registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      paused_reg <= 1'b0;
      quanta_reg <= '0;
      slot_reg <= '0;
    end
    else
    begin
      paused_reg <= paused_next;
      quanta_reg <= quanta_next;
      slot_reg <= slot_next;
    end
  end

  assign o_paused = paused_reg;

  pause_end_a: assert property (@(posedge i_clk) disable iff (i_reset) // R13
    (paused_reg && slot_reg == '0 && quanta_reg == PT_W'(1) && !i_start && i_enable)
    |=> !paused_reg)
    else $error("pause did not end after last quantum");
  slot_reload_a: assert property (@(posedge i_clk) disable iff (i_reset) // R13
    (paused_reg && slot_reg == '0 && quanta_reg > PT_W'(1) && !i_start && i_enable && i_speed_100)
    |=> (paused_reg && slot_reg == SLOT_CNT_W'(SLOT_CYC_100M - 1)))
    else $error("slot counter not reloaded for next quantum");
endmodule
`default_nettype wire

// >>> hw/mfc_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module mfc_top
  import mfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [DATA_W-1:0] o_rdata,
  // management interface engine
  input wire logic i_mgmt_rd_valid,
  input wire logic [MGMT_W-1:0] i_mgmt_rd_data,
  output logic [MGMT_W-1:0] o_mgmt_data,
  // pause frame transmission
  output logic o_pause_tx_req,
  output logic [PT_W-1:0] o_pause_time,
  input wire logic i_pause_tx_done,
  // received pause frames
  input wire logic i_rx_pause_valid,
  input wire logic [PT_W-1:0] i_rx_pause_quanta,
  input wire logic i_speed_100,
  output logic o_tx_pause,
  // transmitted frame classification
  input wire logic i_tx_frame_done,
  input wire logic [LEN_W-1:0] i_tx_frame_len,
  output logic [MXF_W-1:0] o_max_frame_size,
  output logic o_tx_long_frame
);
  logic wr_mgmt, wr_fc, wr_cc, wr_ra, wr_rb, wr_lc;
  logic is_long;

  // write decode
  assign wr_mgmt = i_we && (i_addr == ADDR_MGMT_DATA);
  assign wr_fc = i_we && (i_addr == ADDR_FLOW_CTRL);
  assign wr_cc = i_we && (i_addr == ADDR_CNT_CTRL);
  assign wr_ra = i_we && (i_addr == ADDR_RSVD_A);
  assign wr_rb = i_we && (i_addr == ADDR_RSVD_B);
  assign wr_lc = i_we && (i_addr == ADDR_LONG_CNT);

  // management data word
  logic [MGMT_W-1:0] mgmt_reg, mgmt_next;

  always_comb
  begin
    mgmt_next = mgmt_reg;
    if (i_mgmt_rd_valid)
      mgmt_next = i_mgmt_rd_data; // R1
    else if (wr_mgmt)
      mgmt_next = i_wdata[MGMT_LSB +: MGMT_W]; // R1
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      mgmt_reg <= MGMT_RESET;
    else
      mgmt_reg <= mgmt_next;
  end

  // flow control: pause time, enable, busy state
  logic [PT_W-1:0] pt_reg, pt_next;
  logic fce_reg, fce_next;
  mfc_ptx_state_t ptx_reg, ptx_next;
  logic busy;

  assign busy = (ptx_reg == MFC_PTX_BUSY);

  always_comb
  begin
    pt_next = pt_reg;
    fce_next = fce_reg;
    ptx_next = ptx_reg;
    if (wr_fc)
    begin
      pt_next = i_wdata[PT_LSB +: PT_W]; // R2
      fce_next = i_wdata[FCE_BIT]; // R3
    end
    case (ptx_reg)
      MFC_PTX_IDLE:
      begin
        // a host write of one starts a pause frame
        if (wr_fc && i_wdata[FCB_BIT])
          ptx_next = MFC_PTX_BUSY; // R4
      end
      MFC_PTX_BUSY:
      begin
        // held until the transmitter reports the frame sent and no write of one to bit 0 comes in that cycle
        if (i_pause_tx_done && !(wr_fc && i_wdata[FCB_BIT]))
          ptx_next = MFC_PTX_IDLE; // R6
        else
          ptx_next = MFC_PTX_BUSY; // R5
      end
      default:
        ptx_next = MFC_PTX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pt_reg <= PT_RESET;
      fce_reg <= FCE_RESET;
      ptx_reg <= MFC_PTX_IDLE;
    end
    else
    begin
      pt_reg <= pt_next;
      fce_reg <= fce_next;
      ptx_reg <= ptx_next;
    end
  end

  // counter control, reserved words and long frame count
  logic [MXF_W-1:0] mxf_reg, mxf_next;
  logic ccr_reg, ccr_next;
  logic [DATA_W-1:0] rsa_reg, rsa_next;
  logic [DATA_W-1:0] rsb_reg, rsb_next;
  logic [DATA_W-1:0] lc_reg, lc_next;
  logic long_reg, long_next;

  // compare against the limit in force for this frame
  assign is_long = i_tx_frame_done && (i_tx_frame_len > LEN_W'(mxf_reg)); // R9

  always_comb
  begin
    mxf_next = mxf_reg;
    ccr_next = ccr_reg;
    rsa_next = rsa_reg;
    rsb_next = rsb_reg;
    lc_next = lc_reg;
    long_next = is_long;
    if (wr_cc)
    begin
      mxf_next = i_wdata[MXF_LSB +: MXF_W]; // R8
      ccr_next = i_wdata[CC_RSVD_BIT]; // R10
    end
    if (wr_ra)
      rsa_next = i_wdata; // R11
    if (wr_rb)
      rsb_next = i_wdata; // R12
    // a write clears the count, a long frame in the same cycle still counts
    if (wr_lc)
      lc_next = is_long ? DATA_W'(1) : '0;
    else if (is_long)
      lc_next = lc_reg + DATA_W'(1); // R9
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mxf_reg <= MXF_RESET;
      ccr_reg <= CC_RSVD_RESET;
      rsa_reg <= RSVD_RESET;
      rsb_reg <= RSVD_RESET;
      lc_reg <= '0;
      long_reg <= 1'b0;
    end
    else
    begin
      mxf_reg <= mxf_next;
      ccr_reg <= ccr_next;
      rsa_reg <= rsa_next;
      rsb_reg <= rsb_next;
      lc_reg <= lc_next;
      long_reg <= long_next;
    end
  end

  // read data stands only in the cycle after the read strobe
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  always_comb
  begin
    rdata_next = '0;
    if (i_re)
    begin
      case (i_addr)
        ADDR_MGMT_DATA:
          rdata_next[MGMT_LSB +: MGMT_W] = mgmt_reg;
        ADDR_FLOW_CTRL:
        begin
          rdata_next[PT_LSB +: PT_W] = pt_reg;
          rdata_next[FCE_BIT] = fce_reg;
          rdata_next[FCB_BIT] = busy;
        end
        ADDR_CNT_CTRL:
        begin
          rdata_next[MXF_LSB +: MXF_W] = mxf_reg;
          rdata_next[CC_RSVD_BIT] = ccr_reg;
        end
        ADDR_RSVD_A:
          rdata_next = rsa_reg;
        ADDR_RSVD_B:
          rdata_next = rsb_reg;
        ADDR_LONG_CNT:
          rdata_next = lc_reg;
        default:
          rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  // receive pause handling
  mfc_pause_timer u_pause_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_enable(fce_reg),
    .i_start(i_rx_pause_valid), // R3
    .i_quanta(i_rx_pause_quanta),
    .i_speed_100(i_speed_100),
    .o_paused(o_tx_pause)
  );

  // outputs straight from registers
  assign o_rdata = rdata_reg;
  assign o_mgmt_data = mgmt_reg;
  assign o_pause_tx_req = busy; // R5
  assign o_pause_time = pt_reg; // R2
  assign o_max_frame_size = mxf_reg; // R8
  assign o_tx_long_frame = long_reg;

  mgmt_write_a: assert property (@(posedge i_clk) disable iff (i_reset) // R1
    (wr_mgmt && !i_mgmt_rd_valid) |=> (o_mgmt_data == $past(i_wdata[15:0])))
    else $error("management data not taken from write");
  pause_time_a: assert property (@(posedge i_clk) disable iff (i_reset) // R2
    wr_fc |=> (o_pause_time == $past(i_wdata[31:16])))
    else $error("pause time not taken from write");
  rx_pause_a: assert property (@(posedge i_clk) disable iff (i_reset) // R3
    (i_rx_pause_valid && fce_reg && !wr_fc && i_rx_pause_quanta != 16'h0000)
    |=> o_tx_pause)
    else $error("received pause frame did not stop transmitter");
  busy_hold_a: assert property (@(posedge i_clk) disable iff (i_reset) // R5
    (o_pause_tx_req && !i_pause_tx_done) |=> o_pause_tx_req)
    else $error("busy dropped before pause frame was sent");
  busy_clear_a: assert property (@(posedge i_clk) disable iff (i_reset) // R6
    (o_pause_tx_req && i_pause_tx_done && !wr_fc) |=> !o_pause_tx_req)
    else $error("busy not cleared after pause frame was sent");
  max_frame_a: assert property (@(posedge i_clk) disable iff (i_reset) // R8
    wr_cc |=> (o_max_frame_size == $past(i_wdata[13:3])))
    else $error("maximum frame size not taken from bits 3 to 13");
  long_count_a: assert property (@(posedge i_clk) disable iff (i_reset) // R9
    (i_tx_frame_done && i_tx_frame_len > {5'h00, o_max_frame_size} && !wr_lc)
    |=> (lc_reg == $past(lc_reg) + 32'h0000_0001 && o_tx_long_frame))
    else $error("long frame not counted");
  short_frame_a: assert property (@(posedge i_clk) disable iff (i_reset) // R9
    (!(i_tx_frame_done && i_tx_frame_len > {5'h00, o_max_frame_size}) && !wr_lc)
    |=> ($stable(lc_reg) && !o_tx_long_frame))
    else $error("frame within limit was counted");
endmodule
`default_nettype wire

// >>> test/mfc_link_model.sv
`timescale 1ns/1ns
`default_nettype none
// transmitter and remote node: sends the requested pause frame after a delay
module mfc_link_model
  import mfc_pkg::*;
#(
  parameter int DELAY = 20
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pause_tx_req,
  input wire logic [PT_W-1:0] i_pause_time,
  output logic o_pause_tx_done,
  output logic [PT_W-1:0] o_seen_time
);
  int cnt_reg;
  // count while a request stands, pulse done once, rearm when it drops
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cnt_reg <= 0;
      o_pause_tx_done <= 1'b0;
      o_seen_time <= '0;
    end
    else
    begin
      o_pause_tx_done <= i_pause_tx_req && (cnt_reg == DELAY);
      if (!i_pause_tx_req)
        cnt_reg <= 0;
      else if (cnt_reg <= DELAY)
        cnt_reg <= cnt_reg + 1;
      if (i_pause_tx_req && cnt_reg == 0)
        o_seen_time <= i_pause_time; // time field as sent on the wire
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mfc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_we = 1'b0;
  logic i_re = 1'b0;
  logic i_mgmt_rd_valid = 1'b0;
  logic [MGMT_W-1:0] i_mgmt_rd_data = '0;
  logic i_rx_pause_valid = 1'b0;
  logic [PT_W-1:0] i_rx_pause_quanta = '0;
  logic i_speed_100 = 1'b1;
  logic i_tx_frame_done = 1'b0;
  logic [LEN_W-1:0] i_tx_frame_len = '0;
  logic i_pause_tx_done;
  logic [DATA_W-1:0] o_rdata;
  logic [MGMT_W-1:0] o_mgmt_data;
  logic o_pause_tx_req;
  logic [PT_W-1:0] o_pause_time;
  logic o_tx_pause;
  logic [MXF_W-1:0] o_max_frame_size;
  logic o_tx_long_frame;
  logic [PT_W-1:0] seen_time;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  mfc_top mfc_top_inst (.i_clk, .i_reset, .i_addr, .i_wdata, .i_we, .i_re, .o_rdata,
    .i_mgmt_rd_valid, .i_mgmt_rd_data, .o_mgmt_data, .o_pause_tx_req, .o_pause_time,
    .i_pause_tx_done, .i_rx_pause_valid, .i_rx_pause_quanta, .i_speed_100, .o_tx_pause,
    .i_tx_frame_done, .i_tx_frame_len, .o_max_frame_size, .o_tx_long_frame);
  mfc_link_model mfc_link_model_inst (.i_clk, .i_reset, .i_pause_tx_req(o_pause_tx_req),
    .i_pause_time(o_pause_time), .o_pause_tx_done(i_pause_tx_done), .o_seen_time(seen_time));
  // clock and hang guard
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      $display("Error at %0t: run did not finish in time", $time);
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  // received pause frame, then measure how long the transmitter holds off
  task automatic pz(input logic [15:0] q, input int e);
    @(posedge i_clk);
    i_rx_pause_valid <= 1'b1;
    i_rx_pause_quanta <= q;
    @(posedge i_clk);
    i_rx_pause_valid <= 1'b0;
    i_rx_pause_quanta <= ~q;
    #1;
    n = 0;
    while (o_tx_pause === 1'b1 && n < 6000)
    begin
      n++;
      @(posedge i_clk);
      #1;
    end
    chk(n, e);
  endtask
  task automatic fr(input logic [15:0] l, input logic e);
    @(posedge i_clk);
    i_tx_frame_done <= 1'b1;
    i_tx_frame_len <= l;
    @(posedge i_clk);
    i_tx_frame_done <= 1'b0;
    i_tx_frame_len <= ~l;
    #1;
    chk(o_tx_long_frame, e);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(ADDR_FLOW_CTRL, 32'h0050_0002);
    rd(ADDR_CNT_CTRL, 32'h0000_2F72);
    rd(12'h200, 32'h0000_0000);
    chk(o_max_frame_size, 11'h5EE);
    $display("reset test done");
    wr(ADDR_MGMT_DATA, 32'h1234_ABCD);
    chk(o_mgmt_data, 16'hABCD);
    rd(ADDR_MGMT_DATA, 32'h0000_ABCD);
    @(posedge i_clk);
    i_mgmt_rd_valid <= 1'b1;
    i_mgmt_rd_data <= 16'h5A5A;
    @(posedge i_clk);
    i_mgmt_rd_valid <= 1'b0;
    i_mgmt_rd_data <= 16'hA5A5;
    rd(ADDR_MGMT_DATA, 32'h0000_5A5A);
    wr(ADDR_RSVD_A, 32'hFFFF_FFFF);
    wr(ADDR_RSVD_B, 32'hFFFF_FFFF);
    rd(ADDR_RSVD_A, 32'hFFFF_FFFF);
    rd(ADDR_RSVD_B, 32'hFFFF_FFFF);
    wr(ADDR_CNT_CTRL, 32'h0000_0322);
    rd(ADDR_CNT_CTRL, 32'h0000_0322);
    chk(o_max_frame_size, 11'h064);
    $display("register test done");
    rd(ADDR_FLOW_CTRL, 32'h0050_0002);
    wr(ADDR_FLOW_CTRL, 32'h0010_0003);
    chk(o_pause_tx_req, 1'b1);
    chk(o_pause_time, 16'h0010);
    rd(ADDR_FLOW_CTRL, 32'h0010_0003);
    n = 0;
    while (o_pause_tx_req === 1'b1 && n < 100)
    begin
      n++;
      @(posedge i_clk);
      #1;
    end
    rd(ADDR_FLOW_CTRL, 32'h0010_0002);
    chk(seen_time, 16'h0010);
    $display("pause request test done");
    i_speed_100 <= 1'b0;
    pz(16'h0001, 2560);
    i_speed_100 <= 1'b1;
    pz(16'h0002, 512);
    pz(16'h0000, 0);
    wr(ADDR_FLOW_CTRL, 32'h0010_0000);
    pz(16'h0002, 0);
    $display("pause receive test done");
    fr(16'd100, 1'b0);
    fr(16'd101, 1'b1);
    fr(16'd1519, 1'b1);
    rd(ADDR_LONG_CNT, 32'h0000_0002);
    wr(ADDR_LONG_CNT, 32'h0000_0000);
    rd(ADDR_LONG_CNT, 32'h0000_0000);
    $display("long frame test done");
    // reset in mid-run brings flow control and counter control back to their reset values
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(ADDR_FLOW_CTRL, 32'h0050_0002);
    rd(ADDR_CNT_CTRL, 32'h0000_2F72);
    $display("second reset test done");
    end_of_test();
  end
endmodule
`default_nettype wire
